// *** pbrc_device.sv ***
`timescale 1ns/1ps
`include "pbrc_map.svh"
module pbrc_device import pbrc_pkg::*; (
  input logic clk_i,
  input logic reset_i,
  input logic host_mode_i,
  input logic newer_variant_i,
  input logic [7:0] gen_err_i,
  input logic [7:0] arb_err_i,
  input logic [3:0] dma_done_i,
  input logic addr_parity_err_i,
  input logic parity_err_i,
  input logic master_abort_i,
  input logic target_abort_rx_i,
  input logic target_abort_sig_i,
  input logic data_parity_i,
  output logic [7:0] irq_o,
  output logic [2:0] irq_top_o,
  output logic irq_any_o,
  output logic [1:0] power_state_o,
  pbrc_link_if.device link
);
  pbrc_dev_t s, n;
  logic take, wr, io, blocked, misaligned, drive, hard_rst;
  logic [1:0] new_ps;
  logic [3:0] dma_clr;
  logic [31:0] old_cfg, merged, lane_mask, st_clr;
  logic [31:0] st_set;

  localparam logic [31:0] ST_MASK = (32'h1 << `PBRC_ST_DPE) | (32'h1 << `PBRC_ST_SSE)
    | (32'h1 << `PBRC_ST_RMA) | (32'h1 << `PBRC_ST_RTA)
    | (32'h1 << `PBRC_ST_STA) | (32'h1 << `PBRC_ST_DPD);

  assign take = link.req && !s.ack;
  assign wr = link.cmd[0];
  assign io = !link.cmd[1];
  assign blocked = s.ctrl[`PBRC_CTRL_RST]
    && !(io && wr && link.addr == `PBRC_IO_CTRL);
  assign misaligned = io && (link.addr[1:0] != 2'h0 || link.be_n != 4'h0);
  assign drive = s.cfg_cmd[`PBRC_SER_BIT]
    && (s.ctrl[`PBRC_CTRL_SERR] || addr_parity_err_i);
  // only reset_i and, as non-host, the por link reset
  assign hard_rst = reset_i || (!host_mode_i && !link.sys_por_n);

  always_comb begin
    case (link.addr)
      `PBRC_CFG_CMD: old_cfg = s.cfg_cmd;
      `PBRC_CFG_PM: old_cfg = {30'h00000000, s.pwr_state};
      default: old_cfg = 32'h00000000;
    endcase
  end

  pbrc_lane_merge u_merge (
    .old_i(old_cfg),
    .data_i(link.wdata),
    .be_n_i(link.be_n),
    .all_lanes_i(!newer_variant_i),
    .merged_o(merged),
    .lane_mask_o(lane_mask)
  );

  assign new_ps = merged[1:0];
  assign st_clr = (take && !blocked && !io && wr && link.addr == `PBRC_CFG_CMD)
    ? (link.wdata & lane_mask & ST_MASK) : 32'h00000000;
  assign st_set = ({31'h0, parity_err_i} << `PBRC_ST_DPE)
    | ({31'h0, drive} << `PBRC_ST_SSE)
    | ({31'h0, master_abort_i} << `PBRC_ST_RMA)
    | ({31'h0, target_abort_rx_i} << `PBRC_ST_RTA)
    | ({31'h0, target_abort_sig_i} << `PBRC_ST_STA)
    | ({31'h0, data_parity_i} << `PBRC_ST_DPD);

  genvar g;
  for (g = 0; g < 4; g++) begin : g_dma
    assign dma_clr[g] = take && !blocked && !misaligned && io && wr
      && link.addr[7:4] == `PBRC_IO_DMA_PAGE && link.addr[3:2] == 2'(g)
      && link.wdata[`PBRC_DMA_FLAG];
  end

  always_comb begin
    n = s;
    n.ack = 1'b0;
    n.err = 1'b0;
    if (take) begin
      n.ack = 1'b1;
      n.rdata = 32'h00000000;
      if (blocked || misaligned) begin
        n.err = 1'b1;
      end else if (io && wr) begin
        case (link.addr)
          `PBRC_IO_CTRL: begin
            // clearing write touches only that bit
            if (s.ctrl[`PBRC_CTRL_RST] && !link.wdata[`PBRC_CTRL_RST]) begin
              n.ctrl[`PBRC_CTRL_RST] = 1'b0;
            end else begin
              n.ctrl = link.wdata[1:0];
            end
          end
          `PBRC_IO_GEN_FLAGS: n.gen_flags = s.gen_flags & ~link.wdata[7:0];
          `PBRC_IO_GEN_MASK: n.gen_mask = link.wdata[7:0];
          `PBRC_IO_ARB_FLAGS: n.arb_flags = s.arb_flags & ~link.wdata[7:0];
          `PBRC_IO_ARB_MASK: n.arb_mask = link.wdata[7:0];
          `PBRC_IO_PM_FLAGS: n.pm_flags = s.pm_flags & ~link.wdata[1:0];
          `PBRC_IO_PM_MASK: n.pm_mask = link.wdata[1:0];
          `PBRC_IO_SERR_STAT: n.serr_seen = s.serr_seen & !link.wdata[0];
          default: begin
            if (link.addr[7:4] == `PBRC_IO_DMA_PAGE) begin
              n.dma_mask[link.addr[3:2]] = link.wdata[`PBRC_DMA_MASK];
            end
          end
        endcase
      end else if (io) begin
        case (link.addr)
          `PBRC_IO_CTRL: n.rdata = {30'h00000000, s.ctrl};
          `PBRC_IO_GEN_FLAGS: n.rdata = {24'h000000, s.gen_flags};
          `PBRC_IO_GEN_MASK: n.rdata = {24'h000000, s.gen_mask};
          `PBRC_IO_ARB_FLAGS: n.rdata = {24'h000000, s.arb_flags};
          `PBRC_IO_ARB_MASK: n.rdata = {24'h000000, s.arb_mask};
          `PBRC_IO_PM_FLAGS: n.rdata = {30'h00000000, s.pm_flags};
          `PBRC_IO_PM_MASK: n.rdata = {30'h00000000, s.pm_mask};
          `PBRC_IO_SERR_STAT: n.rdata = {31'h00000000, s.serr_seen};
          default: begin
            if (link.addr[7:4] == `PBRC_IO_DMA_PAGE) begin
              n.rdata = {30'h00000000, s.dma_mask[link.addr[3:2]],
                s.dma_flag[link.addr[3:2]]};
            end
          end
        endcase
      end else if (wr) begin
        if (link.addr == `PBRC_CFG_CMD) begin
          n.cfg_cmd = (merged & `PBRC_CFG_WMASK) | (s.cfg_cmd & ~`PBRC_CFG_WMASK);
        end else if (link.addr == `PBRC_CFG_PM) begin
          // only d0 and d3 exist; other codes keep the state
          if (new_ps == `PBRC_PS_D0 || new_ps == `PBRC_PS_D3) begin
            n.pwr_state = new_ps;
          end
          if (s.pwr_state == `PBRC_PS_D0 && new_ps == `PBRC_PS_D3) begin
            n.pm_flags[`PBRC_PM_D3] = 1'b1;
          end
          if (s.pwr_state == `PBRC_PS_D3 && new_ps == `PBRC_PS_D0) begin
            n.pm_flags[`PBRC_PM_D0] = 1'b1;
          end
        end
      end else begin
        n.rdata = old_cfg;
      end
    end
    // events set after clears so a same-cycle event wins
    // status bits
    // writable half from this cycle's write, so software can clear enable bits
    n.cfg_cmd = (s.cfg_cmd & ~`PBRC_CFG_WMASK & ~ST_MASK)
      | (n.cfg_cmd & `PBRC_CFG_WMASK & ~ST_MASK) | ((s.cfg_cmd & ~st_clr) & ST_MASK)
      | st_set;
    n.gen_flags = n.gen_flags | gen_err_i;
    n.arb_flags = n.arb_flags | arb_err_i;
    n.dma_flag = (s.dma_flag & ~dma_clr) | dma_done_i;
    // line low seen only as host
    n.serr_seen = n.serr_seen | (host_mode_i && !link.serr_n);
    if (n.ctrl[`PBRC_CTRL_RST]) begin
      n.ctrl[`PBRC_CTRL_SERR] = 1'b0;
      n.gen_flags = 8'h00;
      n.arb_flags = 8'h00;
      n.gen_mask = `PBRC_MASK8_RST;
      n.arb_mask = `PBRC_MASK8_RST;
      n.pm_flags = 2'h0;
      n.pm_mask = `PBRC_MASK2_RST;
      n.serr_seen = 1'b0;
      n.dma_flag = 4'h0;
      n.dma_mask = `PBRC_MASK4_RST;
    end
    n.rst_n_out = !(host_mode_i && n.ctrl[`PBRC_CTRL_RST]);
    n.serr_oe_n = !drive;
    n.irq[0] = n.serr_seen;
    n.irq[1] = |(n.gen_flags & ~n.gen_mask) || |(n.arb_flags & ~n.arb_mask);
    n.irq[2] = n.pm_flags[`PBRC_PM_D3] && !n.pm_mask[`PBRC_PM_D3];
    n.irq[3] = n.pm_flags[`PBRC_PM_D0] && !n.pm_mask[`PBRC_PM_D0];
    n.irq[7:4] = n.dma_flag & ~n.dma_mask;
    n.top = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (n.irq[i]) begin
        n.top = 3'(i);
      end
    end
    n.any = |n.irq;
  end

  always_ff @(posedge clk_i) begin
    if (hard_rst) begin
      s <= '0;
      s.gen_mask <= `PBRC_MASK8_RST;
      s.arb_mask <= `PBRC_MASK8_RST;
      s.pm_mask <= `PBRC_MASK2_RST;
      s.dma_mask <= `PBRC_MASK4_RST;
      s.cfg_cmd <= `PBRC_CFG_CMD_RST;
      s.pwr_state <= `PBRC_PS_D0;
      s.serr_oe_n <= 1'b1;
      s.rst_n_out <= 1'b0;
    end else begin
      s <= n;
    end
  end

  assign irq_o = s.irq;
  assign irq_top_o = s.top;
  assign irq_any_o = s.any;
  assign power_state_o = s.pwr_state;
  assign link.ack = s.ack;
  assign link.err = s.err;
  assign link.rdata = s.rdata;
  assign link.pci_rst_n = s.rst_n_out;
  assign link.serr_o = 1'b0;
  assign link.serr_oe_n = s.serr_oe_n;
endmodule

// *** pbrc_host.sv ***
`timescale 1ns/1ps
`include "pbrc_map.svh"
module pbrc_host import pbrc_pkg::*; #(
  parameter int HOLD_CYCLES = `PBRC_RST_HOLD_CYC,
  parameter int POR_CYCLES = `PBRC_RST_HOLD_CYC
) (
  input logic clk_i,
  input logic reset_i,
  input logic pci_clk_run_i,
  input logic [7:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input logic [31:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic [7:0] s_axi_araddr_i,
  input logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  pbrc_link_if.host link
);
  localparam logic [16:0] HOLD_LAST = 17'(HOLD_CYCLES - 1);
  localparam logic [16:0] POR_LAST = 17'(POR_CYCLES - 1);
  pbrc_host_t s, n;
  logic ctrl_wr, clr_wr, blk;

  assign ctrl_wr = (s.cmd == PBRC_IOWR) && (s.addr == `PBRC_IO_CTRL);
  assign clr_wr = ctrl_wr && !s.wbuf[`PBRC_CTRL_RST] && s.rst_held;
  assign blk = (clr_wr && (s.hold_cnt != 17'h00000))
    || (ctrl_wr && s.wbuf[`PBRC_CTRL_RST] && !pci_clk_run_i);

  always_comb begin
    n = s;
    if (s.hold_cnt != 17'h00000) begin
      n.hold_cnt = s.hold_cnt - 17'h00001;
    end
    if (s.por_cnt != POR_LAST) begin
      n.por_cnt = s.por_cnt + 17'h00001;
    end else begin
      n.por_n = 1'b1;
    end
    if (s_axi_awvalid_i && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      case (s.awaddr)
        `PBRC_H_ADDR: begin
          n.addr = s.wdata[7:0];
          n.be_n = s.wdata[11:8];
        end
        `PBRC_H_WDATA: n.wbuf = s.wdata;
        `PBRC_H_CMD: begin
          if (s.fsm == PBRC_H_IDLE) begin
            n.cmd = s.wdata[1:0];
            n.fsm = PBRC_H_WAIT;
          end
        end
        default: ;
      endcase
    end
    if (s.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.arready) begin
      n.rvalid = 1'b1;
      case (s_axi_araddr_i)
        `PBRC_H_CMD: n.rdata = {30'h00000000, s.cmd};
        `PBRC_H_ADDR: n.rdata = {20'h00000, s.be_n, s.addr};
        `PBRC_H_WDATA: n.rdata = s.wbuf;
        `PBRC_H_STAT: n.rdata = {27'h0000000, !s.por_n, !link.pci_rst_n,
          !link.serr_n, s.err, s.fsm != PBRC_H_IDLE};
        `PBRC_H_RDATA: n.rdata = s.rbuf;
        default: n.rdata = 32'h00000000;
      endcase
    end
    case (s.fsm)
      PBRC_H_WAIT: begin
        if (!blk) begin
          n.fsm = PBRC_H_ISSUE;
          n.req = 1'b1;
          n.lwd = clr_wr ? 32'h00000000 : s.wbuf;
        end
      end
      PBRC_H_ISSUE, PBRC_H_SPLIT: begin
        if (link.ack) begin
          n.req = 1'b0;
          n.err = link.err;
          n.rbuf = link.rdata;
          n.fsm = PBRC_H_IDLE;
          if (ctrl_wr && !link.err) begin
            n.rst_held = s.wbuf[`PBRC_CTRL_RST];
            n.hold_cnt = s.wbuf[`PBRC_CTRL_RST] ? HOLD_LAST : 17'h00000;
          end
          if (s.fsm == PBRC_H_ISSUE && clr_wr && s.wbuf != 32'h00000000) begin
            n.fsm = PBRC_H_SPLIT;
            n.req = 1'b1;
            n.lwd = s.wbuf;
          end
        end
      end
      default: ;
    endcase
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= '0;
      s.fsm <= PBRC_H_IDLE;
      s.be_n <= 4'hF;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o = s.wready;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = 2'h0;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = 2'h0;
  assign link.req = s.req;
  assign link.cmd = s.cmd;
  assign link.addr = s.addr;
  assign link.be_n = s.cmd[1] ? s.be_n : 4'h0;
  assign link.wdata = s.lwd;
  assign link.sys_por_n = s.por_n;
endmodule

// *** pbrc_lane_merge.sv ***
`timescale 1ns/1ps
module pbrc_lane_merge (
  input logic [31:0] old_i,
  input logic [31:0] data_i,
  input logic [3:0] be_n_i,
  input logic all_lanes_i,
  output logic [31:0] merged_o,
  output logic [31:0] lane_mask_o
);
  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    logic en;
    assign en = all_lanes_i || !be_n_i[g];
    assign lane_mask_o[g*8 +: 8] = {8{en}};
    assign merged_o[g*8 +: 8] = en ? data_i[g*8 +: 8] : old_i[g*8 +: 8];
  end
endmodule

// *** pbrc_link_asserts.sv ***
`timescale 1ns/1ps
module pbrc_link_asserts import pbrc_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req,
  input wire logic [1:0] cmd,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [31:0] rdata,
  input wire logic pci_rst_n
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence taken_s;
    req && !ack;
  endsequence
  sequence ctrl_wr_s;
    taken_s ##0 (cmd == PBRC_IOWR && addr == 8'h00);
  endsequence
  ack_single_a: assert property (ack |=> !ack)
    else $error("link ack held longer than one cycle");
  ack_latency_a: assert property (taken_s |=> ack)
    else $error("link ack not one cycle after request");
  req_hold_a: assert property (taken_s |=> req && $stable(cmd) && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");
  err_with_ack_a: assert property (err |-> ack)
    else $error("error flag without ack");
  io_align_a: assert property (taken_s ##0 (!cmd[1] && addr[1:0] != 2'h0) |=> ack && err)
    else $error("misaligned io access not refused");
  write_rdata_a: assert property (taken_s ##0 cmd[0] |=> rdata == 32'h0)
    else $error("read data not zero on write");
  bus_reset_set_a: assert property (ctrl_wr_s ##0 wdata[0] |=> ##[0:2] !pci_rst_n)
    else $error("bus reset not driven after control set");
  bus_reset_clr_a: assert property (ctrl_wr_s ##0 !wdata[0] |=> ##[0:2] pci_rst_n)
    else $error("bus reset not released after control clear");
  reset_block_a: assert property (taken_s ##0 (!pci_rst_n && !(cmd == PBRC_IOWR && addr == 8'h00))
    |=> ack && err)
    else $error("access served during soft reset");
endmodule

// *** pbrc_link_if.sv ***
`timescale 1ns/1ps
interface pbrc_link_if;
  logic req;
  logic [1:0] cmd;
  logic [7:0] addr;
  logic [3:0] be_n;
  logic [31:0] wdata;
  logic ack;
  logic err;
  logic [31:0] rdata;
  logic pci_rst_n;
  logic sys_por_n;
  logic serr_o;
  logic serr_oe_n;
  logic serr_n;
  // open-drain line with pull-up
  assign serr_n = serr_oe_n ? 1'b1 : serr_o;
  modport device (
    input req, cmd, addr, be_n, wdata, sys_por_n, serr_n,
    output ack, err, rdata, pci_rst_n, serr_o, serr_oe_n
  );
  modport host (
    output req, cmd, addr, be_n, wdata, sys_por_n,
    input ack, err, rdata, pci_rst_n, serr_n
  );
endinterface

// *** pbrc_map.svh ***
`ifndef PBRC_MAP_SVH
`define PBRC_MAP_SVH
// device i/o register byte offsets
`define PBRC_IO_CTRL 8'h00
`define PBRC_IO_GEN_FLAGS 8'h04
`define PBRC_IO_GEN_MASK 8'h08
`define PBRC_IO_ARB_FLAGS 8'h0C
`define PBRC_IO_ARB_MASK 8'h10
`define PBRC_IO_PM_FLAGS 8'h14
`define PBRC_IO_PM_MASK 8'h18
`define PBRC_IO_SERR_STAT 8'h1C
`define PBRC_IO_DMA_PAGE 4'h2
// configuration space byte offsets
`define PBRC_CFG_CMD 8'h04
`define PBRC_CFG_PM 8'h44
// field positions
`define PBRC_CTRL_RST 0
`define PBRC_CTRL_SERR 1
`define PBRC_SER_BIT 8
`define PBRC_ST_DPE 31
`define PBRC_ST_SSE 30
`define PBRC_ST_RMA 29
`define PBRC_ST_RTA 28
`define PBRC_ST_STA 27
`define PBRC_ST_DPD 24
`define PBRC_PM_D0 0
`define PBRC_PM_D3 1
`define PBRC_DMA_FLAG 0
`define PBRC_DMA_MASK 1
`define PBRC_PS_D0 2'h0
`define PBRC_PS_D3 2'h3
// reset values
`define PBRC_MASK8_RST 8'hFF
`define PBRC_MASK2_RST 2'h3
`define PBRC_MASK4_RST 4'hF
`define PBRC_CFG_CMD_RST 32'h00000000
`define PBRC_CFG_WMASK 32'h0000FFFF
// host controller register byte offsets
`define PBRC_H_CMD 8'h00
`define PBRC_H_ADDR 8'h04
`define PBRC_H_WDATA 8'h08
`define PBRC_H_STAT 8'h0C
`define PBRC_H_RDATA 8'h10
// timing
`define PBRC_CLK_PERIOD_NS 10
`define PBRC_RST_HOLD_MS 1
`define PBRC_RST_HOLD_CYC (`PBRC_RST_HOLD_MS * 1000000 / `PBRC_CLK_PERIOD_NS)
`endif

// *** pbrc_pkg.sv ***
package pbrc_pkg;
  typedef enum logic [1:0] {
    PBRC_IORD = 2'h0,
    PBRC_IOWR = 2'h1,
    PBRC_CFGRD = 2'h2,
    PBRC_CFGWR = 2'h3
  } pbrc_cmd_t;

  typedef enum logic [1:0] {
    PBRC_H_IDLE = 2'h0,
    PBRC_H_WAIT = 2'h1,
    PBRC_H_ISSUE = 2'h3,
    PBRC_H_SPLIT = 2'h2
  } pbrc_hfsm_t;

  typedef struct packed {
    logic [1:0] ctrl;
    logic [7:0] gen_flags;
    logic [7:0] gen_mask;
    logic [7:0] arb_flags;
    logic [7:0] arb_mask;
    logic [1:0] pm_flags;
    logic [1:0] pm_mask;
    logic serr_seen;
    logic [3:0] dma_flag;
    logic [3:0] dma_mask;
    logic [31:0] cfg_cmd;
    logic [1:0] pwr_state;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic rst_n_out;
    logic serr_oe_n;
    logic [7:0] irq;
    logic [2:0] top;
    logic any;
  } pbrc_dev_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] cmd;
    logic [7:0] addr;
    logic [3:0] be_n;
    logic [31:0] wbuf;
    logic [31:0] rbuf;
    logic err;
    pbrc_hfsm_t fsm;
    logic req;
    logic [31:0] lwd;
    logic rst_held;
    logic [16:0] hold_cnt;
    logic [16:0] por_cnt;
    logic por_n;
  } pbrc_host_t;
endpackage

// *** tb_pci_bridge_reset_irq_cfg.sv ***
`timescale 1ns/1ps
module tb_pci_bridge_reset_irq_cfg import pbrc_pkg::*;;
  localparam int HOLD = 100;
  logic clk_i, reset_i, run, host_mode, newer, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, gen_err, arb_err, mi;
  logic [31:0] wdata, cm, d;
  logic [3:0] dma_done;
  logic [5:0] ev;
  logic awready, wready, bvalid, arready, rvalid, any;
  logic [31:0] rdata, r;
  logic [1:0] bresp, rresp, pstate;
  logic [7:0] irq;
  logic [2:0] top;
  logic er;
  int fails, checked, serr_lo, low_n, n1;
  pbrc_link_if link_i();
  pbrc_host #(.HOLD_CYCLES(HOLD), .POR_CYCLES(HOLD)) pbrc_host_i(.clk_i(clk_i), .reset_i(reset_i),
    .pci_clk_run_i(run), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .link(link_i));
  pbrc_device pbrc_device_i(.clk_i(clk_i), .reset_i(reset_i), .host_mode_i(host_mode),
    .newer_variant_i(newer), .gen_err_i(gen_err), .arb_err_i(arb_err), .dma_done_i(dma_done),
    .addr_parity_err_i(ev[0]), .parity_err_i(ev[1]), .master_abort_i(ev[2]),
    .target_abort_rx_i(ev[3]), .target_abort_sig_i(ev[4]), .data_parity_i(ev[5]),
    .irq_o(irq), .irq_top_o(top), .irq_any_o(any), .power_state_o(pstate), .link(link_i));
  pbrc_link_asserts pbrc_link_asserts_i(.clk_i(clk_i), .reset_i(reset_i), .req(link_i.req),
    .cmd(link_i.cmd), .addr(link_i.addr), .wdata(link_i.wdata), .ack(link_i.ack),
    .err(link_i.err), .rdata(link_i.rdata), .pci_rst_n(link_i.pci_rst_n));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // wire watchers: serr line and bus reset duration
  always @(posedge clk_i) begin
    if (!link_i.serr_n) serr_lo <= serr_lo + 1;
    if (!reset_i && !link_i.pci_rst_n) low_n <= low_n + 1;
  end
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task hang;
    fails++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    tally_and_finish();
  endtask
  task axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid && n < 300);
    bready <= 1'h0;
    if (n >= 300) hang();
    chk(bresp, 2'h0, "write response");
  endtask
  task axr(input logic [7:0] a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (!rvalid && n < 300);
    v = rdata;
    rready <= 1'h0;
    if (n >= 300) hang();
    chk(rresp, 2'h0, "read response");
  endtask
  task go(input logic [1:0] c, input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    axw(8'h04, {20'h0, be, a});
    axw(8'h08, v);
    axw(8'h00, {30'h0, c});
  endtask
  task fin(output logic [31:0] rd, output logic e);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      axr(8'h0C, s);
      n++;
    end while (s[0] && n < 200);
    if (n >= 200) hang();
    e = s[1];
    axr(8'h10, rd);
  endtask
  task xfer(input logic [1:0] c, input logic [7:0] a, input logic [3:0] be, input logic [31:0] v,
    input logic [31:0] e, input logic ee);
    go(c, a, be, v);
    fin(r, er);
    chk(er, ee, "link error flag");
    chk(r, e, "link read data");
  endtask
  task pulse(input logic [7:0] g, input logic [7:0] a, input logic [3:0] dd, input logic [5:0] e);
    @(posedge clk_i);
    gen_err <= g;
    arb_err <= a;
    dma_done <= dd;
    ev <= e;
    @(posedge clk_i);
    gen_err <= 8'h00;
    arb_err <= 8'h00;
    dma_done <= 4'h0;
    ev <= 6'h00;
    repeat (2) @(posedge clk_i);
  endtask
  function automatic logic [31:0] merge(input logic [31:0] o, v, input logic [3:0] be, logic nv);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) m[8*i+:8] = (nv && be[i]) ? 8'h00 : 8'hFF;
    m = m & 32'h0000FFFF;
    return (o & ~m) | (v & m);
  endfunction
  task irqchk(input logic [7:0] e);
    logic [2:0] t;
    t = 3'h0;
    for (int i = 7; i >= 0; i--) if (e[i]) t = 3'(i);
    chk(irq, e, "irq lines");
    chk(top, t, "irq top");
    chk(any, |e, "irq any");
  endtask
  initial begin
    reset_i = 1'h1;
    run = 1'h1;
    host_mode = 1'h1;
    newer = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, gen_err, arb_err} = 32'h0;
    {wdata, dma_done, ev} = 42'h0;
    {fails, checked, serr_lo, low_n} = 0;
    cm = 32'h0;
    mi = 8'h00;
    void'($urandom(9633));
    repeat (16) @(posedge clk_i);
    chk(link_i.pci_rst_n, 1'h0, "bus reset at power-on");
    reset_i <= 1'h0;
    irqchk(8'h00);
    xfer(0, 8'h08, 4'h0, 0, 32'hFF, 0);
    xfer(0, 8'h20, 4'h0, 0, 32'h2, 0);
    xfer(1, 8'h05, 4'h0, 0, 0, 1);
    xfer(0, 8'h30, 4'h0, 0, 0, 0);
    axr(8'h40, d);
    d = 32'($urandom_range(255, 0));
    xfer(1, 8'h10, 4'h0, d, 0, 0);
    xfer(0, 8'h10, 4'h0, 0, d, 0);
    $display("test io access done");
    for (int v = 0; v < 2; v++) begin
      newer <= v[0];
      for (int b = 0; b < 16; b++) begin
        d = $urandom;
        xfer(3, 8'h04, b[3:0], d, 0, 0);
        cm = merge(cm, d, b[3:0], v[0]);
        xfer(2, 8'h04, 4'h0, 0, cm, 0);
      end
    end
    $display("test config lanes done");
    pulse(8'($urandom_range(255, 1)), 8'h00, 4'h1, 6'h00);
    irqchk(8'h00);
    xfer(1, 8'h08, 4'h0, 0, 0, 0);
    irqchk(8'h02);
    xfer(1, 8'h04, 4'h0, 32'hFF, 0, 0);
    irqchk(8'h00);
    xfer(1, 8'h10, 4'h0, 0, 0, 0);
    pulse(8'h00, 8'($urandom_range(255, 1)), 4'h0, 6'h00);
    irqchk(8'h02);
    for (int k = 0; k < 4; k++) xfer(1, 8'(8'h20 + 4 * k), 4'h0, 0, 0, 0);
    irqchk(8'h12);
    pulse(8'h00, 8'h00, 4'hE, 6'h00);
    irqchk(8'hF2);
    xfer(1, 8'h20, 4'h0, 1, 0, 0);
    irqchk(8'hE2);
    xfer(1, 8'h24, 4'h0, 2, 0, 0);
    irqchk(8'hC2);
    $display("test interrupts done");
    xfer(1, 8'h18, 4'h0, 0, 0, 0);
    xfer(3, 8'h44, 4'h0, 3, 0, 0);
    irqchk(8'hC6);
    chk(pstate, 2'h3, "power state");
    xfer(3, 8'h44, 4'h0, 0, 0, 0);
    irqchk(8'hCE);
    xfer(3, 8'h44, 4'h0, 1, 0, 0);
    chk(pstate, 2'h0, "power state");
    xfer(0, 8'h14, 4'h0, 0, 3, 0);
    $display("test power done");
    xfer(3, 8'h04, 4'h0, 32'h100, 0, 0);
    n1 = serr_lo;
    pulse(8'h00, 8'h00, 4'h0, 6'h3F);
    chk(serr_lo > n1, 1'h1, "error line driven");
    irqchk(8'hCF);
    xfer(2, 8'h04, 4'h0, 0, 32'hF9000100, 0);
    xfer(0, 8'h1C, 4'h0, 0, 1, 0);
    xfer(1, 8'h1C, 4'h0, 1, 0, 0);
    xfer(3, 8'h04, 4'h0, 32'hF9000000, 0, 0);
    irqchk(8'hCE);
    n1 = serr_lo;
    pulse(8'h00, 8'h00, 4'h0, 6'h01);
    chk(serr_lo, n1, "error line gated");
    xfer(2, 8'h04, 4'h0, 0, 0, 0);
    $display("test system error done");
    run <= 1'h0;
    low_n <= 0;
    go(1, 8'h00, 4'h0, 1);
    // set must wait for the bus clock
    repeat (10) @(posedge clk_i);
    chk(link_i.pci_rst_n, 1'h1, "reset before bus clock");
    run <= 1'h1;
    fin(r, er);
    chk(link_i.pci_rst_n, 1'h0, "soft bus reset");
    xfer(0, 8'h08, 4'h0, 0, 0, 1);
    xfer(1, 8'h00, 4'h0, 2, 0, 0);
    chk(low_n >= HOLD, 1'h1, "reset hold time");
    chk(link_i.pci_rst_n, 1'h1, "bus reset released");
    xfer(0, 8'h00, 4'h0, 0, 2, 0);
    xfer(0, 8'h08, 4'h0, 0, 32'hFF, 0);
    irqchk(8'h00);
    $display("test soft reset done");
    // second reset, now as non-host: the device waits for the power-on level
    host_mode <= 1'h0;
    reset_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'h0;
    n1 = 0;
    while (!link_i.sys_por_n && n1 < 1000) begin
      @(posedge clk_i);
      n1++;
    end
    chk(n1 >= HOLD, 1'h1, "power-on pulse length");
    xfer(0, 8'h08, 4'h0, 0, 32'hFF, 0);
    n1 = serr_lo;
    xfer(3, 8'h04, 4'h0, 32'h100, 0, 0);
    xfer(1, 8'h00, 4'h0, 2, 0, 0);
    chk(serr_lo > n1, 1'h1, "error line by request");
    irqchk(8'h00);
    $display("test non-host done");
    tally_and_finish();
  end
endmodule
